// file: dv/adcas_conv_model.sv
// Converter model: each result is built from the channel and a scan tag.
`timescale 1ns/1ps
module adcas_conv_model (
  // Clock.
  input  wire       clk,
  // Converter side.
  input  wire [3:0] conv_channel,
  input  wire       conv_start,
  input  wire [3:0] scan_tag,
  output reg  [9:0] conv_result
);
  reg go_q;
  // The result register settles after the start and holds to the next one.
  always @(posedge clk) begin
    go_q <= conv_start;
    if (go_q) begin
      conv_result <= {conv_channel, 2'b01, scan_tag};
    end
  end
  initial conv_result = 10'h000;
endmodule // adcas_conv_model

// file: dv/adcas_monitor.sv
// Port checker for the autoscan sequencer.
`timescale 1ns/1ps
module adcas_monitor (
  // Clock and reset.
  input wire clk,
  input wire sys_rst,
  // Watched outputs.
  input wire conv_start,
  input wire conv_sample,
  input wire conv_clk,
  input wire conv_power_down,
  input wire scan_done_irq,
  input wire threshold_watch_irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // No conversion is shorter than 56 cycles, so eight is a safe floor.
  sequence quiet_s;
    !conv_start [*8];
  endsequence
  sequence held_s;
    conv_sample [*8];
  endsequence
  start_spacing_a: assert property (
    conv_start |=> quiet_s)
    else $error("conversion start repeated too soon");
  sample_follow_a: assert property (
    conv_start |-> ##[0:2] conv_sample)
    else $error("start without sampling");
  sample_len_a: assert property (
    $rose(conv_sample) |-> held_s)
    else $error("sampling phase cut short");
  clk_runs_a: assert property (
    conv_sample |-> ##[1:16] $changed(conv_clk))
    else $error("converter clock stuck while sampling");
  power_idle_a: assert property (
    conv_power_down && $past(conv_power_down) |-> !conv_clk && !conv_start)
    else $error("converter active while powered down");
  reset_quiet_a: assert property (
    $past(sys_rst) |-> !conv_start && !scan_done_irq && !threshold_watch_irq)
    else $error("activity right after reset");
  watch_first_a: assert property (
    threshold_watch_irq |-> !scan_done_irq)
    else $error("done request not held behind watchdog");
  power_nosamp_a: assert property (
    conv_power_down && $past(conv_power_down) |-> !conv_sample)
    else $error("sampling while powered down");
endmodule // adcas_monitor

bind adcas_sequencer adcas_monitor mon (.clk(clk), .sys_rst(sys_rst),
  .conv_start(conv_start), .conv_sample(conv_sample), .conv_clk(conv_clk),
  .conv_power_down(conv_power_down), .scan_done_irq(scan_done_irq),
  .threshold_watch_irq(threshold_watch_irq));

// file: dv/test_adc_autoscan_sequencer.sv
// Self-checking bench for the autoscan sequencer.
`timescale 1ns/1ps
`include "adcas_map.vh"
module test_adc_autoscan_sequencer;
  reg         clk;
  reg         sys_rst;
  reg         hwrite;
  reg         outside_trigger_pin;
  reg         inside_trigger_signal;
  reg  [1:0]  htrans;
  reg  [11:0] haddr;
  reg  [31:0] hwdata;
  reg  [31:0] rd;
  reg  [3:0]  scan_tag;
  wire        hreadyout;
  wire        hresp;
  wire        conv_start;
  wire        conv_sample;
  wire        conv_clk;
  wire        conv_power_down;
  wire        scan_done_irq;
  wire        threshold_watch_irq;
  wire [3:0]  conv_channel;
  wire [2:0]  irq_priority;
  wire [9:0]  conv_result;
  wire [31:0] hrdata;
  integer     err_count;
  integer     num_checks;
  integer     gap;

  adcas_sequencer dut (.clk(clk), .sys_rst(sys_rst), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .outside_trigger_pin(outside_trigger_pin),
    .inside_trigger_signal(inside_trigger_signal),
    .conv_channel(conv_channel), .conv_start(conv_start),
    .conv_sample(conv_sample), .conv_clk(conv_clk),
    .conv_power_down(conv_power_down), .conv_result(conv_result),
    .scan_done_irq(scan_done_irq),
    .threshold_watch_irq(threshold_watch_irq), .irq_priority(irq_priority));
  adcas_conv_model model (.clk(clk), .conv_channel(conv_channel),
    .conv_start(conv_start), .scan_tag(scan_tag), .conv_result(conv_result));

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function [9:0] val(input [3:0] ch, input [3:0] tag);
    val = {ch, 2'b01, tag};
  endfunction
  task check(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // One single word transfer; the read data is taken at the closing edge.
  task bus(input wr, input [11:0] a, input [31:0] d);
    begin
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
    end
  endtask
  // Counts idle edges until the next start, giving up after lim.
  task next_start(input integer lim, input [3:0] ch);
    begin
      gap = 0;
      @(posedge clk);
      while (conv_start !== 1'b1 && gap < lim) begin
        gap = gap + 1;
        @(posedge clk);
      end
      @(posedge clk);
      // A long limit means a start is due, so running out is a mismatch.
      if (gap < lim) check(conv_channel, ch);
      else if (lim > 1000) check(gap, 0);
    end
  endtask
  // One-cycle trigger pulse; returning at once lets the start be seen.
  task pulse(input outside);
    begin
      if (outside) outside_trigger_pin <= 1'b1;
      else inside_trigger_signal <= 1'b1;
      @(posedge clk);
      outside_trigger_pin <= 1'b0;
      inside_trigger_signal <= 1'b0;
    end
  endtask
  // Waits for the done request, then clears its pending bit.
  task done_wait;
    begin
      gap = 0;
      while (scan_done_irq !== 1'b1 && gap < 3000) begin
        gap = gap + 1;
        @(posedge clk);
      end
      check(scan_done_irq, 1'b1);
      bus(1'b1, `ADCAS_OFF_IRQ_CTRL, 32'h00000004);
    end
  endtask
  task t_reset;
    begin
      bus(1'b0, `ADCAS_OFF_CTRL_TWO, 32'h0);
      check(rd, 32'h00000000);
      check(hresp, 1'b0);
      bus(1'b0, `ADCAS_OFF_THR_A_UP, 32'h0);
      check(rd, 32'h000003FF);
      bus(1'b1, 12'h0F0, 32'hFFFFFFFF);
      bus(1'b0, 12'h0F0, 32'h0);
      check(rd, 32'h00000000);
      bus(1'b1, `ADCAS_OFF_CTRL_TWO, 32'h00000009);
      next_start(300, 4'h0);
      check(gap, 300);
      check(conv_power_down, 1'b1);
      bus(1'b1, `ADCAS_OFF_CTRL_TWO, 32'h00000000);
    end
  endtask
  task t_single;
    begin
      scan_tag <= 4'h3;
      bus(1'b1, `ADCAS_OFF_CTRL_ONE, 32'h0000000E);
      bus(1'b1, `ADCAS_OFF_IRQ_CTRL, 32'h00000004);
      bus(1'b1, `ADCAS_OFF_CTRL_TWO, 32'h00000015);
      next_start(3000, 4'hE);
      next_start(3000, 4'hF);
      check(gap, 56 * 2 - 2);
      done_wait;
      bus(1'b0, `ADCAS_OFF_CTRL_TWO, 32'h0);
      check(rd, 32'h00000014);
      bus(1'b0, `ADCAS_OFF_DATA_BASE + 12'h038, 32'h0);
      check(rd, {16'h0000, val(4'hE, 4'h3), 6'h00});
      bus(1'b0, `ADCAS_OFF_DATA_BASE + 12'h03C, 32'h0);
      check(rd, {16'h0000, val(4'hF, 4'h3), 6'h00});
      next_start(300, 4'h0);
      check(gap, 300);
    end
  endtask
  task t_trig;
    begin
      scan_tag <= 4'h5;
      bus(1'b1, `ADCAS_OFF_CTRL_ONE, 32'h0000010F);
      bus(1'b1, `ADCAS_OFF_CTRL_TWO, 32'h0000000C);
      pulse(1'b0);
      next_start(200, 4'h0);
      check(gap, 200);
      pulse(1'b1);
      next_start(3000, 4'hF);
      pulse(1'b1);
      done_wait;
      next_start(200, 4'h0);
      check(gap, 200);
      bus(1'b0, `ADCAS_OFF_DATA_BASE + 12'h03C, 32'h0);
      check(rd, {16'h0000, val(4'hF, 4'h5), 6'h00});
      scan_tag <= 4'h6;
      bus(1'b1, `ADCAS_OFF_CTRL_ONE, 32'h0000020F);
      pulse(1'b0);
      next_start(3000, 4'hF);
      done_wait;
    end
  endtask
  task t_cont;
    begin
      scan_tag <= 4'h7;
      bus(1'b1, `ADCAS_OFF_CTRL_ONE, 32'h0000000E);
      bus(1'b1, `ADCAS_OFF_CTRL_TWO, 32'h0000000F);
      next_start(3000, 4'hE);
      next_start(3000, 4'hF);
      check(gap, 56 - 2);
      next_start(3000, 4'hE);
      check(scan_done_irq, 1'b1);
      bus(1'b1, `ADCAS_OFF_CTRL_TWO, 32'h0000000E);
      next_start(3000, 4'hF);
      next_start(300, 4'h0);
      check(gap, 300);
      done_wait;
    end
  endtask
  task t_watch;
    begin
      scan_tag <= 4'h9;
      bus(1'b1, `ADCAS_OFF_CTRL_ONE, 32'h000000EE);
      bus(1'b1, `ADCAS_OFF_THR_A_UP, {22'h0, val(4'hE, 4'h9)});
      bus(1'b1, `ADCAS_OFF_THR_A_LO, {22'h0, val(4'hE, 4'h9)});
      bus(1'b1, `ADCAS_OFF_THR_B_UP, {22'h0, val(4'hF, 4'h9) + 10'h001});
      bus(1'b1, `ADCAS_OFF_THR_B_LO, {22'h0, val(4'hF, 4'h9) + 10'h001});
      bus(1'b1, `ADCAS_OFF_IRQ_CTRL, 32'h0000005C);
      bus(1'b1, `ADCAS_OFF_CTRL_TWO, 32'h0000000D);
      rd = 32'h1;
      gap = 0;
      while (rd[0] !== 1'b0 && gap < 100) begin
        gap = gap + 1;
        bus(1'b0, `ADCAS_OFF_CTRL_TWO, 32'h0);
      end
      @(posedge clk);
      check(threshold_watch_irq, 1'b1);
      check(scan_done_irq, 1'b0);
      check(irq_priority, 3'h5);
      bus(1'b0, `ADCAS_OFF_CMP_RES, 32'h0);
      check(rd, 32'h00000009);
      bus(1'b0, `ADCAS_OFF_IRQ_CTRL, 32'h0);
      check(rd, 32'h0000005F);
      bus(1'b1, `ADCAS_OFF_IRQ_CTRL, 32'h0000005D);
      repeat (2) @(posedge clk);
      check(scan_done_irq, 1'b1);
      check(threshold_watch_irq, 1'b0);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  // A hang is cut short well past the longest expected run.
  initial begin
    repeat (40000) @(posedge clk);
    err_count = err_count + 1;
    final_report;
  end
  // Main sequence: reset for eight cycles, then each scenario in turn.
  initial begin
    err_count = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 12'h000;
    hwdata = 32'h0;
    scan_tag = 4'h0;
    outside_trigger_pin = 1'b0;
    inside_trigger_signal = 1'b0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_single;
    t_trig;
    t_cont;
    t_watch;
    final_report;
  end
endmodule // test_adc_autoscan_sequencer

// file: rtl/adcas_map.vh
// Register offsets, field positions and timing counts.
`ifndef ADCAS_MAP_VH
`define ADCAS_MAP_VH
`define ADCAS_OFF_DATA_BASE 12'h000
`define ADCAS_OFF_CTRL_ONE  12'h040
`define ADCAS_OFF_CTRL_TWO  12'h044
`define ADCAS_OFF_IRQ_CTRL  12'h048
`define ADCAS_OFF_CMP_RES   12'h04C
`define ADCAS_OFF_THR_A_UP  12'h050
`define ADCAS_OFF_THR_A_LO  12'h054
`define ADCAS_OFF_THR_B_UP  12'h058
`define ADCAS_OFF_THR_B_LO  12'h05C
`define ADCAS_C2_GO         0
`define ADCAS_C2_CONT       1
`define ADCAS_C2_POW        2
`define ADCAS_C2_PR_LSB     3
`define ADCAS_C2_PR_MSB     5
`define ADCAS_C1_FIRST_LSB  0
`define ADCAS_C1_FIRST_MSB  3
`define ADCAS_C1_PAIR_LSB   4
`define ADCAS_C1_PAIR_MSB   7
`define ADCAS_C1_OUT_GATE   8
`define ADCAS_C1_IN_GATE    9
`define ADCAS_IC_DONE       0
`define ADCAS_IC_WATCH      1
`define ADCAS_IC_DONE_EN    2
`define ADCAS_IC_WATCH_EN   3
`define ADCAS_IC_PRI_LSB    4
`define ADCAS_IC_PRI_MSB    6
`define ADCAS_SAMPLE_MULT   8
`define ADCAS_CONV_MULT     28
`define ADCAS_FCONV_MAX_MHZ 4
`define ADCAS_CLK_MHZ       100
`endif

// file: rtl/adcas_sequencer.v
// Autoscan sequencer for a 10-bit SAR converter, with AHB-Lite registers.
`timescale 1ns/1ps
`include "adcas_map.vh"

module adcas_sequencer (
  // Clock and reset.
  input  wire        clk,
  input  wire        sys_rst,
  // AHB-Lite slave.
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Triggers.
  input  wire        outside_trigger_pin,
  input  wire        inside_trigger_signal,
  // Analog converter side.
  output reg  [3:0]  conv_channel,
  output reg         conv_start,
  output reg         conv_sample,
  output reg         conv_clk,
  output reg         conv_power_down,
  input  wire [9:0]  conv_result,
  // Interrupt requests.
  output reg         scan_done_irq,
  output reg         threshold_watch_irq,
  output reg  [2:0]  irq_priority
);

  // Sequencer states.
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SAMP = 3'b010;
  localparam [2:0] ST_CONV = 3'b100;

  // Register state.
  reg  [9:0]  data_q [0:15];
  reg  [3:0]  first_channel_select_q;
  reg  [3:0]  watch_pair_select_q;
  reg         outside_trigger_gate_q;
  reg         inside_trigger_gate_q;
  reg         scan_go_flag_q;
  reg         cont_q;
  reg         pow_q;
  reg  [2:0]  prescale_factor_q;
  reg         done_pend_q;
  reg         watch_pend_q;
  reg         done_en_q;
  reg         watch_en_q;
  reg  [2:0]  pri_q;
  reg  [3:0]  cmp_res_q;
  reg  [9:0]  thr_q [0:3];
  // Sequencer state.
  reg  [2:0]  state_q;
  reg  [3:0]  chan_q;
  reg  [7:0]  div_q;
  reg  [5:0]  tick_q;
  reg         cont_run_q;
  // Trigger synchronisers.
  reg  [1:0]  ext_sync_q;
  reg  [1:0]  int_sync_q;
  reg         ext_prev_q;
  reg         int_prev_q;
  // AHB data phase.
  reg         dph_wr_q;
  reg  [11:0] dph_addr_q;

  // Decodes a word address into a data channel index or flags none.
  function [4:0] data_index;
    input [11:0] a;
    begin
      if (a[11:6] == `ADCAS_OFF_DATA_BASE >> 6)
        data_index = {1'b1, a[5:2]};
      else
        data_index = 5'h00;
    end
  endfunction

  // Watchdog window check on one result.
  function watch_bad;
    input [9:0] v;
    input [9:0] up;
    input [9:0] lo;
    begin
      watch_bad = (v >= up) || (v < lo);
    end
  endfunction

  wire       acc    = hsel && hready && htrans[1];
  wire       wr_en  = dph_wr_q;
  wire [4:0] wr_dix = data_index(dph_addr_q);
  wire [4:0] rd_dix = data_index(haddr);
  wire [31:0] w     = hwdata;

  // A conversion period counts prescaled half-rate converter clocks.
  wire [7:0] half_div = (prescale_factor_q == 3'h0) ? 8'h01 :
                        {5'h00, prescale_factor_q};
  wire       cclk_tick = (div_q == half_div - 8'h01) && conv_clk;

  // Trigger edges after two flip-flops each.
  wire ext_rise = ext_sync_q[1] && !ext_prev_q;
  wire int_rise = int_sync_q[1] && !int_prev_q;
  wire trig = (ext_rise && outside_trigger_gate_q) ||
              (int_rise && inside_trigger_gate_q);
  wire trig_ok = trig && !scan_go_flag_q && !cont_run_q;

  wire sw_go_wr = wr_en && (dph_addr_q == `ADCAS_OFF_CTRL_TWO);
  wire conv_end = (state_q == ST_CONV) && cclk_tick &&
                  (tick_q == `ADCAS_CONV_MULT - 1);
  wire last_end = conv_end && (chan_q == 4'hF);
  wire [3:0] pair_a = watch_pair_select_q;
  wire [3:0] pair_b = watch_pair_select_q + 4'h1;
  wire bad_au = conv_end && chan_q == pair_a && conv_result >= thr_q[0];
  wire bad_al = conv_end && chan_q == pair_a && conv_result < thr_q[1];
  wire bad_bu = conv_end && chan_q == pair_b && conv_result >= thr_q[2];
  wire bad_bl = conv_end && chan_q == pair_b && conv_result < thr_q[3];
  wire watch_hit = (conv_end && chan_q == pair_a &&
                    watch_bad(conv_result, thr_q[0], thr_q[1])) ||
                   (conv_end && chan_q == pair_b &&
                    watch_bad(conv_result, thr_q[2], thr_q[3]));

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Synchronisers and AHB address phase capture.
  always @(posedge clk) begin
    if (sys_rst) begin
      ext_sync_q <= 2'b00;
      int_sync_q <= 2'b00;
      ext_prev_q <= 1'b0;
      int_prev_q <= 1'b0;
      dph_wr_q   <= 1'b0;
      dph_addr_q <= 12'h000;
    end else begin
      ext_sync_q <= {ext_sync_q[0], outside_trigger_pin};
      int_sync_q <= {int_sync_q[0], inside_trigger_signal};
      ext_prev_q <= ext_sync_q[1];
      int_prev_q <= int_sync_q[1];
      dph_wr_q   <= acc && hwrite;
      dph_addr_q <= haddr;
    end
  end

  // Read data is registered at the address phase and stands one cycle later.
  always @(posedge clk) begin
    if (sys_rst) begin
      hrdata <= 32'h00000000;
    end else if (acc && !hwrite) begin
      if (rd_dix[4])
        hrdata <= {16'h0000, data_q[rd_dix[3:0]][9:2],
                   data_q[rd_dix[3:0]][1:0], 6'h00};
      else case (haddr)
        `ADCAS_OFF_CTRL_ONE: hrdata <= {22'h0, inside_trigger_gate_q,
                                outside_trigger_gate_q, watch_pair_select_q,
                                first_channel_select_q};
        `ADCAS_OFF_CTRL_TWO: hrdata <= {26'h0, prescale_factor_q,
                                pow_q, cont_q, scan_go_flag_q};
        `ADCAS_OFF_IRQ_CTRL: hrdata <= {25'h0, pri_q, watch_en_q,
                                done_en_q, watch_pend_q, done_pend_q};
        `ADCAS_OFF_CMP_RES:  hrdata <= {28'h0000000, cmp_res_q};
        `ADCAS_OFF_THR_A_UP: hrdata <= {22'h0, thr_q[0]};
        `ADCAS_OFF_THR_A_LO: hrdata <= {22'h0, thr_q[1]};
        `ADCAS_OFF_THR_B_UP: hrdata <= {22'h0, thr_q[2]};
        `ADCAS_OFF_THR_B_LO: hrdata <= {22'h0, thr_q[3]};
        default:             hrdata <= 32'h00000000;
      endcase
    end
  end

  // Control registers; hardware sets win over software clears.
  always @(posedge clk) begin
    if (sys_rst) begin
      first_channel_select_q <= 4'h0;
      watch_pair_select_q    <= 4'h0;
      outside_trigger_gate_q <= 1'b0;
      inside_trigger_gate_q  <= 1'b0;
      scan_go_flag_q         <= 1'b0;
      cont_q                 <= 1'b0;
      pow_q                  <= 1'b0;
      prescale_factor_q      <= 3'h0;
      done_pend_q            <= 1'b0;
      watch_pend_q           <= 1'b0;
      done_en_q              <= 1'b0;
      watch_en_q             <= 1'b0;
      pri_q                  <= 3'h0;
      cmp_res_q              <= 4'h0;
      thr_q[0]               <= 10'h3FF;
      thr_q[1]               <= 10'h000;
      thr_q[2]               <= 10'h3FF;
      thr_q[3]               <= 10'h000;
    end else begin
      if (wr_en) begin
        case (dph_addr_q)
          `ADCAS_OFF_CTRL_ONE: begin
            first_channel_select_q <= w[3:0];
            watch_pair_select_q    <= w[7:4];
            outside_trigger_gate_q <= w[`ADCAS_C1_OUT_GATE];
            inside_trigger_gate_q  <= w[`ADCAS_C1_IN_GATE];
          end
          `ADCAS_OFF_CTRL_TWO: begin
            cont_q            <= w[`ADCAS_C2_CONT];
            pow_q             <= w[`ADCAS_C2_POW];
            prescale_factor_q <= w[`ADCAS_C2_PR_MSB:`ADCAS_C2_PR_LSB];
          end
          `ADCAS_OFF_IRQ_CTRL: begin
            done_en_q <= w[`ADCAS_IC_DONE_EN];
            watch_en_q <= w[`ADCAS_IC_WATCH_EN];
            pri_q     <= w[`ADCAS_IC_PRI_MSB:`ADCAS_IC_PRI_LSB];
          end
          `ADCAS_OFF_THR_A_UP: thr_q[0] <= w[9:0];
          `ADCAS_OFF_THR_A_LO: thr_q[1] <= w[9:0];
          `ADCAS_OFF_THR_B_UP: thr_q[2] <= w[9:0];
          `ADCAS_OFF_THR_B_LO: thr_q[3] <= w[9:0];
          default: ;
        endcase
      end
      // Go flag: software write, trigger set, single-mode self clear.
      if (trig_ok)
        scan_go_flag_q <= 1'b1;
      else if (last_end && !cont_q)
        scan_go_flag_q <= 1'b0;
      else if (sw_go_wr)
        scan_go_flag_q <= w[`ADCAS_C2_GO];
      // Pending flags: software may write either; an event wins.
      if (last_end)
        done_pend_q <= 1'b1;
      else if (wr_en && dph_addr_q == `ADCAS_OFF_IRQ_CTRL)
        done_pend_q <= w[`ADCAS_IC_DONE];
      if (watch_hit)
        watch_pend_q <= 1'b1;
      else if (wr_en && dph_addr_q == `ADCAS_OFF_IRQ_CTRL)
        watch_pend_q <= w[`ADCAS_IC_WATCH];
      // Compare flags clear when the watch flag is cleared by software.
      if (watch_hit)
        cmp_res_q <= cmp_res_q | {bad_au, bad_al, bad_bu, bad_bl};
      else if (!watch_pend_q)
        cmp_res_q <= 4'h0;
    end
  end

  // Scan sequencer; one conversion period must end before the next start.
  always @(posedge clk) begin
    if (sys_rst) begin
      state_q     <= ST_IDLE;
      chan_q      <= 4'h0;
      div_q       <= 8'h00;
      tick_q      <= 6'h00;
      cont_run_q  <= 1'b0;
      conv_clk    <= 1'b0;
      conv_start  <= 1'b0;
      conv_sample <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      // Half period counter then toggle gives the divide by two.
      if (div_q == half_div - 8'h01) begin
        div_q    <= 8'h00;
        conv_clk <= !conv_clk && pow_q;
      end else begin
        div_q <= div_q + 8'h01;
      end
      case (state_q)
        ST_IDLE: begin
          cont_run_q <= 1'b0;
          if (scan_go_flag_q && pow_q && cclk_tick) begin
            chan_q      <= first_channel_select_q;
            conv_start  <= 1'b1;
            conv_sample <= 1'b1;
            tick_q      <= 6'h00;
            cont_run_q  <= cont_q;
            state_q     <= ST_SAMP;
          end
        end
        ST_SAMP: begin
          if (cclk_tick) begin
            tick_q <= tick_q + 6'h01;
            if (tick_q == `ADCAS_SAMPLE_MULT - 1) begin
              conv_sample <= 1'b0;
              state_q     <= ST_CONV;
            end
          end
        end
        ST_CONV: begin
          if (cclk_tick)
            tick_q <= tick_q + 6'h01;
          if (conv_end) begin
            tick_q <= 6'h00;
            if (chan_q != 4'hF) begin
              chan_q      <= chan_q + 4'h1;
              conv_start  <= 1'b1;
              conv_sample <= 1'b1;
              state_q     <= ST_SAMP;
            end else if (cont_q && scan_go_flag_q && !sw_go_wr) begin
              chan_q      <= first_channel_select_q;
              conv_start  <= 1'b1;
              conv_sample <= 1'b1;
              state_q     <= ST_SAMP;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      if (!pow_q) begin
        state_q     <= ST_IDLE;
        conv_sample <= 1'b0;
        conv_start  <= 1'b0;
        conv_clk    <= 1'b0;
      end
    end
  end

  // Result store: each finished conversion replaces the channel's entry.
  always @(posedge clk) begin
    if (conv_end)
      data_q[chan_q] <= conv_result;
    else if (wr_en && wr_dix[4])
      data_q[wr_dix[3:0]] <= {w[15:8], w[7:6]};
  end

  // Interrupt outputs; the watchdog masks a simultaneous done request.
  always @(posedge clk) begin
    if (sys_rst) begin
      scan_done_irq       <= 1'b0;
      threshold_watch_irq <= 1'b0;
      irq_priority        <= 3'h0;
      conv_channel        <= 4'h0;
      conv_power_down     <= 1'b1;
    end else begin
      threshold_watch_irq <= watch_pend_q && watch_en_q;
      scan_done_irq <= done_pend_q && done_en_q &&
                       !(watch_pend_q && watch_en_q);
      irq_priority    <= pri_q;
      conv_channel    <= chan_q;
      conv_power_down <= !pow_q;
    end
  end

endmodule // adcas_sequencer
